/* File: hdl/lic_dev.sv */
// Memory device end: bank state tracking and masked write capture
module lic_dev (
	// Reset from the system domain
	input wire logic RESET_I,
	// Link
	lic_if.dev LNK,
	// Observed state
	output lic_pkg::lic_dev_t DEV_STATE_O,
	output logic [3*lic_pkg::NBANK-1:0] BANK_STATE_O,
	output logic ERR_O,
	// Write beats
	output logic WR_EN_O,
	output logic [lic_pkg::DQ_W-1:0] WR_DATA_O
);
	import lic_pkg::*;

	logic rst_meta_r;
	logic rst_r;
	logic cke_q_r;
	lic_cmd_t cmd;
	logic [TMR_W-1:0] dev_tmr_r;
	lic_bank_t bst_r [NBANK];
	logic [TMR_W-1:0] btm_r [NBANK];
	logic burst_live_r;
	logic burst_rd_r;
	logic [BA_W-1:0] burst_ba_r;
	logic [TMR_W-1:0] burst_cnt_r;
	logic col_new;
	logic bad;
	lic_bank_t tb;

	// Reset crosses into the link domain through two flops
	always_ff @(posedge LNK.ck) begin
		rst_meta_r <= RESET_I;
		rst_r <= rst_meta_r;
	end

	// A command counts only with clock enable high on this and the previous rising edge
	always_ff @(posedge LNK.ck) begin
		if (rst_r) begin
			cke_q_r <= 1'b0;
		end else begin
			cke_q_r <= LNK.cke;
		end
	end
	assign cmd = (cke_q_r && LNK.cke) ? LNK.cmd : CMD_NOP;
	assign col_new = DEV_STATE_O == D_NORM && cmd inside {CMD_RD, CMD_WR};

	// Commands that break a window or have no burst are flagged
	always_comb begin
		tb = bst_r[LNK.ba];
		bad = 1'b0;
		if (cmd != CMD_NOP && !(DEV_STATE_O inside {D_NORM, D_PWRON, D_RSTG})) begin
			bad = 1'b1;
		end
		if (cmd == CMD_BST && !burst_live_r) begin
			bad = 1'b1;
		end
		if (col_new && !(tb inside {B_ACT, B_RD, B_WR})) begin
			bad = 1'b1;
		end
	end

	always_ff @(posedge LNK.ck) begin
		if (rst_r) begin
			ERR_O <= 1'b0;
		end else begin
			ERR_O <= bad;
		end
	end

	// Device-wide state; register windows ignore everything but NOP
	always_ff @(posedge LNK.ck) begin
		if (rst_r) begin
			DEV_STATE_O <= D_PWRON;
			dev_tmr_r <= TMR_ZERO;
		end else if (cmd == CMD_RST && DEV_STATE_O inside {D_PWRON, D_NORM}) begin
			DEV_STATE_O <= D_RSTG;
			dev_tmr_r <= INIT_CYC;
		end else if (cmd == CMD_MRR && DEV_STATE_O inside {D_NORM, D_RSTG}) begin
			DEV_STATE_O <= (DEV_STATE_O == D_NORM) ? D_MRR : D_RMRR;
			dev_tmr_r <= MRR_CYC;
		end else if (cmd == CMD_MRW && DEV_STATE_O == D_NORM) begin
			DEV_STATE_O <= D_MRW;
			dev_tmr_r <= MRW_CYC;
		end else if (cmd == CMD_REF && DEV_STATE_O == D_NORM) begin
			DEV_STATE_O <= D_REF;
			dev_tmr_r <= RFC_CYC;
		end else if (dev_tmr_r != TMR_ZERO) begin
			dev_tmr_r <= dev_tmr_r - 8'h01;
		end else if (DEV_STATE_O == D_RMRR) begin
			DEV_STATE_O <= D_RSTG;
			dev_tmr_r <= INIT_CYC;
		end else if (DEV_STATE_O != D_PWRON) begin
			DEV_STATE_O <= D_NORM;
		end
	end

	// Most recent burst, whatever its bank
	always_ff @(posedge LNK.ck) begin
		if (rst_r) begin
			burst_live_r <= 1'b0;
			burst_rd_r <= 1'b0;
			burst_ba_r <= '0;
			burst_cnt_r <= TMR_ZERO;
		end else if (col_new) begin
			burst_live_r <= 1'b1;
			burst_rd_r <= (cmd == CMD_RD);
			burst_ba_r <= LNK.ba;
			burst_cnt_r <= BL_CYC;
		end else if (cmd == CMD_BST && DEV_STATE_O == D_NORM) begin
			burst_live_r <= 1'b0;
			burst_cnt_r <= TMR_ZERO;
		end else if (burst_cnt_r != TMR_ZERO) begin
			burst_cnt_r <= burst_cnt_r - 8'h01;
			burst_live_r <= (burst_cnt_r != 8'h01);
		end
	end

	// Write beats: mask low stores the data, mask high drops it
	always_ff @(posedge LNK.ck) begin
		if (rst_r) begin
			WR_EN_O <= 1'b0;
			WR_DATA_O <= DQ_ZERO;
		end else begin
			WR_EN_O <= burst_live_r && !burst_rd_r && !LNK.dm;
			WR_DATA_O <= LNK.dq;
		end
	end

	// Per-bank state; other banks run on untouched by NOP or MRR
	for (genvar b = 0; b < NBANK; b++) begin : g_bank
		logic hit;
		logic bend;
		assign hit = DEV_STATE_O == D_NORM && (cmd == CMD_PREA
			|| (LNK.ba == BA_W'(b) && cmd inside
			{CMD_ACT, CMD_RD, CMD_WR, CMD_PRE}));
		// A bank precharged mid-burst must not fall back to active
		assign bend = burst_live_r && burst_ba_r == BA_W'(b)
			&& bst_r[b] inside {B_RD, B_WR, B_RDA, B_WRA}
			&& (burst_cnt_r == 8'h01 || col_new || cmd == CMD_BST);
		always_ff @(posedge LNK.ck) begin
			if (rst_r) begin
				bst_r[b] <= B_IDLE;
				btm_r[b] <= TMR_ZERO;
			end else if (hit) begin
				unique case (cmd)
					CMD_ACT: begin
						bst_r[b] <= B_ACTG;
						btm_r[b] <= RCD_CYC;
					end
					CMD_RD: bst_r[b] <= LNK.ap ? B_RDA : B_RD;
					CMD_WR: bst_r[b] <= LNK.ap ? B_WRA : B_WR;
					default: begin
						bst_r[b] <= B_PRE;
						btm_r[b] <= RP_CYC;
					end
				endcase
			end else if (bend) begin
				bst_r[b] <= (bst_r[b] inside {B_RDA, B_WRA}) ? B_PRE : B_ACT;
				btm_r[b] <= (bst_r[b] inside {B_RDA, B_WRA}) ? RP_CYC : TMR_ZERO;
			end else if (btm_r[b] != TMR_ZERO) begin
				btm_r[b] <= btm_r[b] - 8'h01;
			end else if (bst_r[b] == B_ACTG) begin
				bst_r[b] <= B_ACT;
			end else if (bst_r[b] == B_PRE) begin
				bst_r[b] <= B_IDLE;
			end
		end
		assign BANK_STATE_O[3*b +: 3] = bst_r[b];
	end

endmodule : lic_dev

/* File: hdl/lic_host.sv */
// Controller end: issues commands only when the bank record allows them
module lic_host (
	// System
	input wire logic CLK_I,
	input wire logic RESET_I,
	// Command requests
	input wire logic REQ_VALID_I,
	input wire lic_pkg::lic_cmd_t REQ_CMD_I,
	input wire logic [lic_pkg::BA_W-1:0] REQ_BANK_I,
	input wire logic REQ_AP_I,
	input wire logic [lic_pkg::DQ_W-1:0] REQ_DATA_I,
	input wire logic REQ_MASK_I,
	// Answers
	output logic REQ_DONE_O,
	output logic REQ_REFUSED_O,
	output logic QUIET_O,
	// Link
	lic_if.host LNK
);
	import lic_pkg::*;

	logic ck_r;
	logic slot;
	logic cke_r;
	logic [TMR_W-1:0] cke_cnt_r;
	lic_dev_t dev_r;
	logic [TMR_W-1:0] dev_tmr_r;
	lic_bank_t bst_r [NBANK];
	logic [TMR_W-1:0] btm_r [NBANK];
	logic [TMR_W-1:0] rrd_r;
	logic burst_live_r;
	logic burst_rd_r;
	logic [BA_W-1:0] burst_ba_r;
	logic [TMR_W-1:0] burst_cnt_r;
	logic [DQ_W-1:0] data_r;
	logic mask_r;
	lic_cmd_t cmd_r;
	logic [BA_W-1:0] ba_r;
	logic ap_r;
	logic [DQ_W-1:0] dq_r;
	logic dm_r;
	logic legal;
	logic quiet;
	logic issue;
	logic norm;
	logic all_idle;
	logic all_pre;
	logic all_mrr;
	logic all_stable;
	logic col_new;
	lic_bank_t tb;

	// Link clock divider; commands change as the clock falls
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			ck_r <= 1'b0;
		end else begin
			ck_r <= ~ck_r;
		end
	end
	assign slot = ck_r;

	// Clock enable rises after reset, then a few NOP cycles follow
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			cke_r <= 1'b0;
			cke_cnt_r <= CKE_CYC;
		end else if (slot) begin
			cke_r <= 1'b1;
			if (cke_r && cke_cnt_r != TMR_ZERO) begin
				cke_cnt_r <= cke_cnt_r - 8'h01;
			end
		end
	end

	// Summaries of the bank record
	always_comb begin
		all_idle = 1'b1;
		all_pre = 1'b1;
		all_mrr = 1'b1;
		all_stable = 1'b1;
		for (int i = 0; i < NBANK; i++) begin
			if (bst_r[i] != B_IDLE) begin
				all_idle = 1'b0;
			end
			if (!(bst_r[i] inside {B_IDLE, B_ACT, B_RD, B_WR, B_PRE})) begin
				all_pre = 1'b0;
			end
			if (!(bst_r[i] inside {B_IDLE, B_ACTG, B_ACT, B_PRE})) begin
				all_mrr = 1'b0;
			end
			if (!(bst_r[i] inside {B_IDLE, B_ACT}) || btm_r[i] != TMR_ZERO) begin
				all_stable = 1'b0;
			end
		end
	end

	// Legality of the pending request against the record
	always_comb begin
		tb = bst_r[REQ_BANK_I];
		norm = (dev_r == D_NORM);
		legal = 1'b0;
		if (cke_r && cke_cnt_r == TMR_ZERO) begin
			unique case (REQ_CMD_I)
				CMD_NOP: legal = 1'b1;
				CMD_ACT: legal = norm && tb == B_IDLE && rrd_r == TMR_ZERO;
				CMD_RD: legal = norm && (tb inside {B_ACT, B_RD, B_WR})
					&& !(burst_live_r && !burst_rd_r);
				CMD_WR: legal = norm && (tb inside {B_ACT, B_RD, B_WR})
					&& !(burst_live_r && burst_rd_r);
				CMD_PRE: legal = norm && (tb inside {B_IDLE, B_ACT, B_RD, B_WR});
				CMD_PREA: legal = norm && all_pre;
				CMD_REF: legal = norm && all_idle && !burst_live_r;
				CMD_MRW: legal = norm && all_idle && !burst_live_r;
				CMD_MRR: legal = (norm && all_mrr && !burst_live_r)
					|| dev_r == D_RSTG;
				CMD_BST: legal = norm && burst_live_r;
				CMD_RST: legal = dev_r == D_PWRON
					|| (norm && all_idle && !burst_live_r);
				default: legal = 1'b0;
			endcase
		end
	end

	// Nothing in flight: an illegal request can never become legal
	assign quiet = all_stable && !burst_live_r && rrd_r == TMR_ZERO
		&& dev_tmr_r == TMR_ZERO && cke_cnt_r == TMR_ZERO
		&& dev_r inside {D_PWRON, D_NORM};
	assign issue = slot && REQ_VALID_I && !REQ_DONE_O && legal;
	assign col_new = issue && REQ_CMD_I inside {CMD_RD, CMD_WR};

	// Request answer; timing waits stall, lasting faults are refused
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			REQ_DONE_O <= 1'b0;
			REQ_REFUSED_O <= 1'b0;
		end else begin
			REQ_DONE_O <= slot && REQ_VALID_I && !REQ_DONE_O
				&& (legal || quiet);
			REQ_REFUSED_O <= slot && REQ_VALID_I && !REQ_DONE_O
				&& !legal && quiet;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			QUIET_O <= 1'b0;
		end else begin
			QUIET_O <= quiet;
		end
	end

	// Command pins; only legal commands leave, NOP otherwise
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			cmd_r <= CMD_NOP;
			ba_r <= '0;
			ap_r <= 1'b0;
		end else if (slot) begin
			cmd_r <= issue ? REQ_CMD_I : CMD_NOP;
			ba_r <= REQ_BANK_I;
			ap_r <= REQ_AP_I;
		end
	end

	// Device-wide state mirror
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			dev_r <= D_PWRON;
			dev_tmr_r <= TMR_ZERO;
		end else if (slot) begin
			if (issue && REQ_CMD_I == CMD_RST) begin
				dev_r <= D_RSTG;
				dev_tmr_r <= INIT_CYC;
			end else if (issue && REQ_CMD_I == CMD_MRR) begin
				dev_r <= norm ? D_MRR : D_RMRR;
				dev_tmr_r <= MRR_CYC;
			end else if (issue && REQ_CMD_I == CMD_MRW) begin
				dev_r <= D_MRW;
				dev_tmr_r <= MRW_CYC;
			end else if (issue && REQ_CMD_I == CMD_REF) begin
				dev_r <= D_REF;
				dev_tmr_r <= RFC_CYC;
			end else if (dev_tmr_r != TMR_ZERO) begin
				dev_tmr_r <= dev_tmr_r - 8'h01;
			end else if (dev_r == D_RMRR) begin
				dev_r <= D_RSTG;
				dev_tmr_r <= INIT_CYC;
			end else if (dev_r != D_PWRON) begin
				dev_r <= D_NORM;
			end
		end
	end

	// Activate spacing timer
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			rrd_r <= TMR_ZERO;
		end else if (slot) begin
			if (issue && REQ_CMD_I == CMD_ACT) begin
				rrd_r <= RRD_CYC;
			end else if (rrd_r != TMR_ZERO) begin
				rrd_r <= rrd_r - 8'h01;
			end
		end
	end

	// Most recent burst; a new burst or terminate ends the old one
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			burst_live_r <= 1'b0;
			burst_rd_r <= 1'b0;
			burst_ba_r <= '0;
			burst_cnt_r <= TMR_ZERO;
			data_r <= DQ_ZERO;
			mask_r <= 1'b1;
		end else if (slot) begin
			if (col_new) begin
				burst_live_r <= 1'b1;
				burst_rd_r <= (REQ_CMD_I == CMD_RD);
				burst_ba_r <= REQ_BANK_I;
				burst_cnt_r <= BL_CYC;
				data_r <= REQ_DATA_I;
				mask_r <= REQ_MASK_I;
			end else if (issue && REQ_CMD_I == CMD_BST) begin
				burst_live_r <= 1'b0;
				burst_cnt_r <= TMR_ZERO;
			end else if (burst_cnt_r != TMR_ZERO) begin
				burst_cnt_r <= burst_cnt_r - 8'h01;
				burst_live_r <= (burst_cnt_r != 8'h01);
			end
		end
	end

	// Write beats follow the write command, one per link cycle
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			dq_r <= DQ_ZERO;
			dm_r <= 1'b1;
		end else if (slot) begin
			dq_r <= data_r;
			dm_r <= !(burst_live_r && !burst_rd_r) || mask_r;
		end
	end

	// Per-bank record with countdown timers
	for (genvar b = 0; b < NBANK; b++) begin : g_bank
		logic hit;
		logic bend;
		assign hit = issue && (REQ_CMD_I == CMD_PREA
			|| (REQ_BANK_I == BA_W'(b) && REQ_CMD_I inside
			{CMD_ACT, CMD_RD, CMD_WR, CMD_PRE}));
		// A bank precharged mid-burst must not fall back to active
		assign bend = burst_live_r && burst_ba_r == BA_W'(b)
			&& bst_r[b] inside {B_RD, B_WR, B_RDA, B_WRA}
			&& (burst_cnt_r == 8'h01 || col_new
			|| (issue && REQ_CMD_I == CMD_BST));
		always_ff @(posedge CLK_I) begin
			if (RESET_I) begin
				bst_r[b] <= B_IDLE;
				btm_r[b] <= TMR_ZERO;
			end else if (slot) begin
				if (hit) begin
					unique case (REQ_CMD_I)
						CMD_ACT: begin
							bst_r[b] <= B_ACTG;
							btm_r[b] <= RCD_CYC;
						end
						CMD_RD: bst_r[b] <= REQ_AP_I ? B_RDA : B_RD;
						CMD_WR: bst_r[b] <= REQ_AP_I ? B_WRA : B_WR;
						default: begin
							bst_r[b] <= B_PRE;
							btm_r[b] <= RP_CYC;
						end
					endcase
				end else if (bend) begin
					bst_r[b] <= (bst_r[b] inside {B_RDA, B_WRA}) ? B_PRE : B_ACT;
					btm_r[b] <= (bst_r[b] inside {B_RDA, B_WRA}) ? RP_CYC : TMR_ZERO;
				end else if (btm_r[b] != TMR_ZERO) begin
					btm_r[b] <= btm_r[b] - 8'h01;
				end else if (bst_r[b] == B_ACTG) begin
					bst_r[b] <= B_ACT;
				end else if (bst_r[b] == B_PRE) begin
					bst_r[b] <= B_IDLE;
				end
			end
		end
	end

	// Link pins
	assign LNK.ck = ck_r;
	assign LNK.cke = cke_r;
	assign LNK.cmd = cmd_r;
	assign LNK.ba = ba_r;
	assign LNK.ap = ap_r;
	assign LNK.dq = dq_r;
	assign LNK.dm = dm_r;

endmodule : lic_host

/* File: hdl/lic_if.sv */
// Command and write-data link between controller and memory device
interface lic_if;
	logic ck;
	logic cke;
	lic_pkg::lic_cmd_t cmd;
	logic [lic_pkg::BA_W-1:0] ba;
	logic ap;
	logic [lic_pkg::DQ_W-1:0] dq;
	logic dm;

	modport host (output ck, output cke, output cmd, output ba,
		output ap, output dq, output dm);
	modport dev (input ck, input cke, input cmd, input ba,
		input ap, input dq, input dm);
endinterface : lic_if

/* File: hdl/lic_pkg.sv */
// Shared constants and types for the LPDDR2 inter-bank command checker
package lic_pkg;

	// Structure
	localparam int NBANK = 8;
	localparam int BA_W = 3;
	localparam int DQ_W = 8;
	localparam int TMR_W = 8;

	typedef enum logic [3:0] {
		CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_PREA,
		CMD_REF, CMD_MRW, CMD_MRR, CMD_BST, CMD_RST
	} lic_cmd_t;

	typedef enum logic [2:0] {
		B_IDLE, B_ACTG, B_ACT, B_RD, B_WR, B_RDA, B_WRA, B_PRE
	} lic_bank_t;

	typedef enum logic [2:0] {
		D_PWRON, D_RSTG, D_RMRR, D_NORM, D_MRR, D_MRW, D_REF
	} lic_dev_t;

	// Clocking: the link clock is the system clock divided by two
	localparam int CLK_PERIOD_NS = 50;
	localparam int LINK_DIV = 2;
	localparam int LINK_NS = CLK_PERIOD_NS * LINK_DIV;

	// Times in their own units
	localparam int T_RCD_NS = 18;
	localparam int T_RP_NS = 18;
	localparam int T_RRD_NS = 10;
	localparam int T_RFC_NS = 130;
	localparam int T_INIT_NS = 2000;
	localparam int T_MRR_CK = 2;
	localparam int T_MRW_CK = 5;
	localparam int BURST_LEN = 4;
	localparam int CKE_WAIT_CK = 2;

	// Least times rounded up to whole link cycles
	localparam logic [TMR_W-1:0] RCD_CYC =
		TMR_W'((T_RCD_NS + LINK_NS - 1) / LINK_NS);
	localparam logic [TMR_W-1:0] RP_CYC =
		TMR_W'((T_RP_NS + LINK_NS - 1) / LINK_NS);
	localparam logic [TMR_W-1:0] RRD_CYC =
		TMR_W'((T_RRD_NS + LINK_NS - 1) / LINK_NS);
	localparam logic [TMR_W-1:0] RFC_CYC =
		TMR_W'((T_RFC_NS + LINK_NS - 1) / LINK_NS);
	localparam logic [TMR_W-1:0] INIT_CYC =
		TMR_W'((T_INIT_NS + LINK_NS - 1) / LINK_NS);
	localparam logic [TMR_W-1:0] MRR_CYC = TMR_W'(T_MRR_CK);
	localparam logic [TMR_W-1:0] MRW_CYC = TMR_W'(T_MRW_CK);
	localparam logic [TMR_W-1:0] BL_CYC = TMR_W'(BURST_LEN);
	localparam logic [TMR_W-1:0] CKE_CYC = TMR_W'(CKE_WAIT_CK);

	// Reset values
	localparam logic [TMR_W-1:0] TMR_ZERO = 8'h00;
	localparam logic [DQ_W-1:0] DQ_ZERO = 8'h00;

endpackage : lic_pkg

/* File: testbench/lic_chk.sv */
// Assertions on the link between controller and device ends
module lic_chk (
	// Link
	input wire logic ck,
	input wire logic cke,
	input wire lic_pkg::lic_cmd_t cmd,
	input wire logic [lic_pkg::BA_W-1:0] ba,
	input wire logic ap,
	input wire logic [lic_pkg::DQ_W-1:0] dq,
	input wire logic dm,
	// Device reset and state
	input wire logic RESET_I,
	input wire lic_pkg::lic_dev_t DEV_STATE_O,
	input wire logic [3*lic_pkg::NBANK-1:0] BANK_STATE_O,
	input wire logic ERR_O,
	input wire logic WR_EN_O,
	input wire logic [lic_pkg::DQ_W-1:0] WR_DATA_O
);
	import lic_pkg::*;
	logic cke_r;
	logic tk;
	logic calm;
	logic nb;
	function automatic lic_bank_t bk(input logic [23:0] s, input logic [2:0] b);
		return lic_bank_t'(s[3*b+:3]);
	endfunction : bk
	// Earlier clock enable: a command counts only after two high samples
	always_ff @(posedge ck) begin
		cke_r <= cke;
	end
	assign tk = cke && cke_r && DEV_STATE_O == D_NORM;
	// Calm: every bank idle or active; nb: no burst running anywhere
	always_comb begin
		calm = 1'b1;
		nb = 1'b1;
		for (int i = 0; i < NBANK; i++) begin
			if (!(bk(BANK_STATE_O, 3'(i)) inside {B_IDLE, B_ACT}))
				calm = 1'b0;
			if (bk(BANK_STATE_O, 3'(i)) inside {B_RD, B_WR, B_RDA, B_WRA})
				nb = 1'b0;
		end
	end
	default clocking @(posedge ck); endclocking
	default disable iff (RESET_I);
	property p_nop_hold;
		tk && cmd == CMD_NOP && calm |=> $stable(BANK_STATE_O);
	endproperty
	a_nop_hold: assert property (p_nop_hold) else $error("nop moved a bank");
	property p_act;
		tk && cmd == CMD_ACT && bk(BANK_STATE_O, ba) == B_IDLE |=>
			bk(BANK_STATE_O, $past(ba)) == B_ACTG ##2
			bk(BANK_STATE_O, $past(ba, 3)) == B_ACT;
	endproperty
	a_act: assert property (p_act) else $error("activate timing wrong");
	property p_rd;
		tk && cmd == CMD_RD && bk(BANK_STATE_O, ba) == B_ACT |=>
			bk(BANK_STATE_O, $past(ba)) == ($past(ap) ? B_RDA : B_RD);
	endproperty
	a_rd: assert property (p_rd) else $error("read state wrong");
	property p_bst;
		tk && cmd == CMD_BST |-> !nb ##1 !ERR_O;
	endproperty
	a_bst: assert property (p_bst) else $error("terminate without burst");
	property p_win;
		DEV_STATE_O inside {D_MRR, D_MRW, D_REF} |-> cmd == CMD_NOP;
	endproperty
	a_win: assert property (p_win) else $error("command in window");
	property p_mrr_len;
		$rose(DEV_STATE_O == D_MRR) |->
			##2 DEV_STATE_O == D_MRR ##1 DEV_STATE_O == D_NORM;
	endproperty
	a_mrr_len: assert property (p_mrr_len) else $error("read window length");
	property p_mrw_len;
		$rose(DEV_STATE_O == D_MRW) |->
			##5 DEV_STATE_O == D_MRW ##1 DEV_STATE_O == D_NORM;
	endproperty
	a_mrw_len: assert property (p_mrw_len) else $error("write window length");
	property p_mrr_ok;
		tk && cmd == CMD_MRR && nb |=> DEV_STATE_O == D_MRR && !ERR_O;
	endproperty
	a_mrr_ok: assert property (p_mrr_ok) else $error("register read refused");
	property p_mask;
		WR_EN_O |-> !$past(dm) && WR_DATA_O == $past(dq);
	endproperty
	a_mask: assert property (p_mask) else $error("masked beat written");
endmodule : lic_chk

/* File: testbench/lpddr2_interbank_command_checker_bench.sv */
// Bench joining controller and device, plus a rule-breaking far end
module lpddr2_interbank_command_checker_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import lic_pkg::*;
	logic clk = 1'b0;
	logic rst_h = 1'b1;
	logic rst_d = 1'b1;
	logic rst2 = 1'b1;
	logic valid = 1'b0;
	lic_cmd_t cmd = CMD_NOP;
	logic [BA_W-1:0] bank = 3'h0;
	logic ap = 1'b0;
	logic [DQ_W-1:0] data = 8'h00;
	logic mask = 1'b0;
	logic [DQ_W-1:0] wd = 8'h00;
	logic done, refd, quiet, err, wr_en, err2, r;
	lic_dev_t dev_state, st2;
	logic [3*NBANK-1:0] bank_state;
	logic [DQ_W-1:0] wr_data;
	lic_bank_t exp_b [NBANK];
	lic_cmd_t pick [10] = '{CMD_ACT, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE,
		CMD_PREA, CMD_MRR, CMD_MRW, CMD_REF, CMD_BST};
	int n_errors = 0;
	int checks_done = 0;
	int n_wr = 0;
	lic_if lnk ();
	lic_if lnk2 ();
	always #25 clk = ~clk;
	lic_host i_lic_host (.CLK_I(clk), .RESET_I(rst_h), .REQ_VALID_I(valid),
		.REQ_CMD_I(cmd), .REQ_BANK_I(bank), .REQ_AP_I(ap), .REQ_DATA_I(data),
		.REQ_MASK_I(mask), .REQ_DONE_O(done), .REQ_REFUSED_O(refd),
		.QUIET_O(quiet), .LNK(lnk.host));
	lic_dev i_lic_dev (.RESET_I(rst_d), .LNK(lnk.dev), .DEV_STATE_O(dev_state),
		.BANK_STATE_O(bank_state), .ERR_O(err), .WR_EN_O(wr_en),
		.WR_DATA_O(wr_data));
	lic_dev i_lic_dev_b (.RESET_I(rst2), .LNK(lnk2.dev), .DEV_STATE_O(st2),
		.BANK_STATE_O(), .ERR_O(err2), .WR_EN_O(), .WR_DATA_O());
	lic_chk i_lic_chk (.ck(lnk.ck), .cke(lnk.cke), .cmd(lnk.cmd), .ba(lnk.ba),
		.ap(lnk.ap), .dq(lnk.dq), .dm(lnk.dm), .RESET_I(rst_d),
		.DEV_STATE_O(dev_state), .BANK_STATE_O(bank_state), .ERR_O(err),
		.WR_EN_O(wr_en), .WR_DATA_O(wr_data));
	task automatic cmp_v(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp_v
	task automatic final_report();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report
	task automatic tmo();
		n_errors++;
		$display("MISMATCH t=%0t no answer", $time);
		final_report();
	endtask : tmo
	// Unmasked beats carry the request data; the controller never errs
	always @(negedge lnk.ck) begin
		if (wr_en === 1'b1) begin
			n_wr++;
			cmp_v(24'(wr_data), 24'(wd));
		end
		if (err === 1'b1)
			cmp_v(24'h1, 24'h0);
	end
	function automatic logic legal(input lic_cmd_t c, input logic [2:0] b);
		logic all_idle;
		all_idle = 1'b1;
		foreach (exp_b[i])
			if (exp_b[i] != B_IDLE)
				all_idle = 1'b0;
		case (c)
			CMD_ACT: return exp_b[b] == B_IDLE;
			CMD_RD, CMD_WR: return exp_b[b] == B_ACT;
			CMD_MRW, CMD_REF: return all_idle;
			CMD_BST: return 1'b0;
			default: return 1'b1;
		endcase
	endfunction : legal
	function automatic logic [23:0] pack();
		logic [23:0] v;
		foreach (exp_b[i])
			v[3*i+:3] = exp_b[i];
		return v;
	endfunction : pack
	// Request held until taken; data and mask are fresh each time
	task automatic issue(input lic_cmd_t c, input logic [2:0] b,
			input logic a, output logic rf);
		int i;
		@(posedge clk);
		#2;
		valid = 1'b1;
		cmd = c;
		bank = b;
		ap = a;
		data = DQ_W'($urandom());
		mask = 1'($urandom());
		for (i = 0; i < 600 && done !== 1'b1; i++) begin
			@(posedge clk);
			#2;
		end
		if (i == 600)
			tmo();
		rf = refd;
		// Beats go out after the next call may have drawn new data
		if (c == CMD_WR)
			wd = data;
		valid = 1'b0;
	endtask : issue
	// Extra link cycles after quiet let the last write beat land
	task automatic settle();
		for (int i = 0; i < 400; i++) begin
			@(negedge lnk.ck);
			if (quiet === 1'b1 && bank_state === pack() && dev_state === D_NORM)
				break;
		end
		repeat (3) @(negedge lnk.ck);
		cmp_v(bank_state, pack());
		cmp_v(24'(dev_state), 24'(D_NORM));
		cmp_v(24'(quiet), 24'h1);
	endtask : settle
	task automatic op(input lic_cmd_t c, input logic [2:0] b, input logic a);
		logic ok;
		int w;
		ok = legal(c, b);
		w = n_wr;
		issue(c, b, a, r);
		cmp_v(24'(r), 24'(!ok));
		if (ok && c == CMD_ACT)
			exp_b[b] = B_ACT;
		if (ok && c inside {CMD_RD, CMD_WR})
			exp_b[b] = a ? B_IDLE : B_ACT;
		if (c == CMD_PRE)
			exp_b[b] = B_IDLE;
		if (c == CMD_PREA)
			foreach (exp_b[j])
				exp_b[j] = B_IDLE;
		settle();
		if (ok && c == CMD_WR)
			cmp_v(24'(n_wr - w), mask ? 24'h0 : 24'h4);
	endtask : op
	// Far-end link cycle made by the bench, 80 ns, still between calls
	task automatic tick(input lic_cmd_t c);
		lnk2.cmd = c;
		lnk2.dq = ~lnk2.dq;
		#40 lnk2.ck = 1'b1;
		#40 lnk2.ck = 1'b0;
	endtask : tick
	initial begin
		lnk2.ck = 1'b0;
		lnk2.cke = 1'b0;
		lnk2.cmd = CMD_NOP;
		lnk2.ba = 3'h0;
		lnk2.ap = 1'b0;
		lnk2.dq = 8'h00;
		lnk2.dm = 1'b1;
		void'($urandom(32'hcc78c38a));
		foreach (exp_b[j])
			exp_b[j] = B_IDLE;
		repeat (20) @(posedge clk);
		#2 rst_h = 1'b0;
		repeat (10) @(posedge clk);
		#2 rst_d = 1'b0;
		repeat (10) @(posedge clk);
		cmp_v(bank_state, pack());
		cmp_v(24'(dev_state), 24'(D_PWRON));
		// Reset through the controller, register read while resetting
		issue(CMD_RST, 3'h0, 1'b0, r);
		issue(CMD_MRR, 3'h0, 1'b0, r);
		cmp_v(24'(r), 24'h0);
		settle();
		for (int i = 0; i < 60; i++)
			op(pick[$urandom_range(9, 0)], 3'($urandom()), 1'($urandom()));
		// Back to back: two activates, terminated read, register read in activation
		op(CMD_PREA, 3'h0, 1'b0);
		issue(CMD_ACT, 3'h2, 1'b0, r);
		issue(CMD_ACT, 3'h3, 1'b0, r);
		issue(CMD_RD, 3'h3, 1'b0, r);
		issue(CMD_BST, 3'h3, 1'b0, r);
		cmp_v(24'(r), 24'h0);
		issue(CMD_ACT, 3'h4, 1'b0, r);
		issue(CMD_MRR, 3'h4, 1'b0, r);
		cmp_v(24'(r), 24'h0);
		exp_b[2] = B_ACT;
		exp_b[3] = B_ACT;
		exp_b[4] = B_ACT;
		settle();
		// Turnarounds wait for the running burst; auto precharge bank
		issue(CMD_RD, 3'h2, 1'b1, r);
		issue(CMD_WR, 3'h3, 1'b0, r);
		issue(CMD_RD, 3'h4, 1'b0, r);
		cmp_v(24'(r), 24'h0);
		exp_b[2] = B_IDLE;
		settle();
		// Far end breaking the rules on the second device
		lnk2.cke = 1'b1;
		repeat (4) tick(CMD_NOP);
		rst2 = 1'b0;
		repeat (4) tick(CMD_NOP);
		tick(CMD_RST);
		cmp_v(24'(st2), 24'(D_RSTG));
		tick(CMD_MRR);
		cmp_v(24'(st2), 24'(D_RMRR));
		tick(CMD_ACT);
		cmp_v(24'(err2), 24'h1);
		for (int i = 0; i < 80 && st2 !== D_NORM; i++)
			tick(CMD_NOP);
		cmp_v(24'(st2), 24'(D_NORM));
		tick(CMD_BST);
		cmp_v(24'(err2), 24'h1);
		final_report();
	end
endmodule : lpddr2_interbank_command_checker_bench
